// *** src/qdu_top.sv ***
/*
  Quad DAC update control: serial frame receiver, power modes, clear code,
  load pin and override mask. Assumes the host drives sync/sclk/din, clear
  and load pins asynchronously to clk; sclk well below clk/4.
*/
//
// Contract
// R1: power mode 00 normal, 01 1k, 10 100k, 11 tristate
// R2: power frame command 0100, mode bits 9:8
// R3: bits 3..0 select channels D..A
// R4: clear acts on falling edge only
// R5: clear loads all input and DAC registers
// R6: clear select maps 0000, 8000, FFFF, nop
// R7: clear select resets to zero code
// R8: command 0101 writes clear select bits 1:0
// R9: cleared state ends at next valid frame
// R10: clear during shifting abandons frame
// R11: load low updates DAC on 32nd edge
// R12: load falling edge copies inputs to DACs; code drops the edge in a cycle with frame_done or clear_hit
// R13: command 0010 writes input, updates all
// R14: command 0110 loads override mask bits 3:0
// R15: override bit set updates regardless of pin
// R16: override mask resets to zero
// R17: frame is pad, command, address, data
// R18: early sync rise discards partial frame
// R19: power-down keeps DAC register contents
// R20: unselected channels keep their power mode
`timescale 1ns/1ns
module qdu_top
  import qdu_pkg::*;
(
  input wire logic clk, // 125 MHz core clock
  input wire logic reset_n, // async reset, active low
  input wire logic sync_n, // frame select, active low
  input wire logic sclk, // host serial clock
  input wire logic din, // serial data
  input wire logic async_clear_n, // clear pin, falling edge
  input wire logic load_outputs_n, // load pin, active low
  output logic [63:0] dac_codes, // DAC registers, D..A as [63:48]..[15:0]
  output logic [7:0] power_modes, // per-channel mode, 2 bits each
  output logic clear_active, // in cleared state
  output logic [1:0] clear_code_select, // clear select register
  output logic [3:0] load_override_mask // override mask register
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  qdu_link_t link_s;
  logic clr_s, load_s;

  qdu_sync #(.WIDTH(5), .INIT(5'h1B)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({sync_n, sclk, din, async_clear_n, load_outputs_n}),
    .sync_out({link_s, clr_s, load_s})
  );

  // edge history resets to each pin's idle level, so reset gives no false edge
  logic sclk_d, clr_d, load_d;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_d <= 1'b1;
      clr_d <= 1'b1;
      load_d <= 1'b1;
    end else begin
      sclk_d <= link_s.sclk;
      clr_d <= clr_s;
      load_d <= load_s;
    end
  end

  logic sclk_fall, clr_fall, load_fall;
  assign sclk_fall = sclk_d && !link_s.sclk;
  assign clr_fall = clr_d && !clr_s; // [R4]
  assign load_fall = load_d && !load_s; // [R12]

  // ---------------------------------------------------------------
  // frame shifter
  // ---------------------------------------------------------------
  logic [31:0] shreg;
  logic [5:0] bitcnt;
  logic frame_done;
  logic armed;

  // a frame needs sync high then low; armed blocks re-run after 32 bits
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shreg <= 32'h0000_0000;
      bitcnt <= 6'h00;
      frame_done <= 1'b0;
      armed <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (link_s.sync_n) begin
        bitcnt <= 6'h00; // [R18]
        armed <= 1'b1;
      end else if (clr_fall) begin
        bitcnt <= 6'h00; // [R10]
        armed <= 1'b0;
      end else if (armed && sclk_fall) begin
        shreg <= {shreg[30:0], link_s.din};
        if (bitcnt == 6'(QDU_FRAME_BITS - 1)) begin
          frame_done <= 1'b1; // [R17]
          armed <= 1'b0;
          bitcnt <= 6'h00;
        end else begin
          bitcnt <= bitcnt + 6'h01;
        end
      end
    end
  end

  function automatic qdu_frame_t decode(input logic [31:0] w);
    qdu_frame_t f;
    f.cmd = w[QDU_CMD_LSB +: 4];
    f.addr = w[QDU_ADDR_LSB +: 4];
    f.data = w[QDU_DATA_LSB +: 16];
    f.pmode = w[QDU_PMODE_LSB +: 2];
    f.low4 = w[QDU_CHSEL_LSB +: 4];
    return f;
  endfunction

  function automatic logic [3:0] addr_mask(input logic [3:0] a);
    logic [3:0] m;
    m = 4'h0;
    if (a == QDU_ADDR_ALL) begin
      m = 4'hF;
    end else if (a < 4'h4) begin
      m[a[1:0]] = 1'b1;
    end
    return m;
  endfunction

  logic [3:0] amask;
  // ---------------------------------------------------------------
  // command execution (frame_done follows the 32nd edge by a cycle)
  // ---------------------------------------------------------------
  qdu_frame_t cf;
  assign cf = decode(shreg);
  assign amask = addr_mask(cf.addr);

  logic [63:0] in_q, in_wdata, dac_wdata;
  logic [3:0] in_we, dac_we;
  logic [15:0] clear_code;
  logic clear_hit;

  always_comb begin
    unique case (clear_code_select) // [R6]
      QDU_CLR_ZERO: clear_code = QDU_CODE_ZERO;
      QDU_CLR_MID: clear_code = QDU_CODE_MID;
      QDU_CLR_FULL: clear_code = QDU_CODE_FULL;
      QDU_CLR_NOP: clear_code = QDU_CODE_ZERO;
    endcase
  end
  assign clear_hit = clr_fall && (clear_code_select != QDU_CLR_NOP);

  always_comb begin
    in_we = 4'h0;
    dac_we = 4'h0;
    in_wdata = {4{cf.data}};
    dac_wdata = in_q;
    if (clear_hit) begin
      in_we = 4'hF; // [R5]
      dac_we = 4'hF;
      in_wdata = {4{clear_code}};
      dac_wdata = {4{clear_code}};
    end else if (frame_done) begin
      unique case (cf.cmd)
        QDU_CMD_WRITE_IN: begin
          in_we = amask;
          dac_we = amask & (load_override_mask | {4{!load_s}}); // [R11] [R15]
          dac_wdata = {4{cf.data}};
        end
        QDU_CMD_UPDATE_N: dac_we = amask;
        QDU_CMD_WRITE_ALL: begin
          in_we = amask; // [R13]
          dac_we = 4'hF;
          for (int i = 0; i < 4; i++) begin
            dac_wdata[i*16 +: 16] = amask[i] ? cf.data : in_q[i*16 +: 16];
          end
        end
        QDU_CMD_WRITE_UPD: begin
          in_we = amask;
          dac_we = amask;
          dac_wdata = {4{cf.data}};
        end
        QDU_CMD_RESET: begin
          in_we = 4'hF;
          dac_we = 4'hF;
          in_wdata = {4{QDU_DAC_RESET}};
          dac_wdata = {4{QDU_DAC_RESET}};
        end
        default: ;
      endcase
    end else if (load_fall) begin
      dac_we = 4'hF; // [R12]
    end
  end

  qdu_regmem u_in (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(in_we),
    .wr_data(in_wdata),
    .rd_data(in_q)
  );

  qdu_regmem u_dac (
    .clk(clk),
    .reset_n(reset_n),
    .wr_en(dac_we),
    .wr_data(dac_wdata),
    .rd_data(dac_codes)
  );

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_modes <= {4{QDU_PMODE_RESET}};
    end else if (frame_done && cf.cmd == QDU_CMD_RESET) begin
      power_modes <= {4{QDU_PMODE_RESET}};
    end else if (frame_done && cf.cmd == QDU_CMD_POWER) begin
      for (int i = 0; i < 4; i++) begin
        if (cf.low4[i]) begin
          power_modes[i*2 +: 2] <= cf.pmode; // [R1] [R2] [R3] [R20]
        end
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clear_code_select <= QDU_CLRSEL_RESET; // [R7]
    end else if (frame_done && cf.cmd == QDU_CMD_RESET) begin
      clear_code_select <= QDU_CLRSEL_RESET;
    end else if (frame_done && cf.cmd == QDU_CMD_CLRCODE) begin
      clear_code_select <= shreg[QDU_CLRSEL_LSB +: 2]; // [R8]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      load_override_mask <= QDU_OVERRIDE_RESET; // [R16]
    end else if (frame_done && cf.cmd == QDU_CMD_RESET) begin
      load_override_mask <= QDU_OVERRIDE_RESET;
    end else if (frame_done && cf.cmd == QDU_CMD_OVERRIDE) begin
      load_override_mask <= cf.low4; // [R14]
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clear_active <= 1'b0;
    end else if (clear_hit) begin
      clear_active <= 1'b1; // set wins over the frame end
    end else if (frame_done) begin
      clear_active <= 1'b0; // [R9]
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // mode selects widened to the two-bit fields, and the addressed DAC code
  logic [7:0] sel_pairs;
  logic [15:0] addr_dac;
  assign sel_pairs = {{2{cf.low4[3]}}, {2{cf.low4[2]}}, {2{cf.low4[1]}}, {2{cf.low4[0]}}};
  assign addr_dac = dac_codes[{cf.addr[1:0], 4'h0} +: 16];
  chk_clear_loads: assert property (@(posedge clk) disable iff (!reset_n) // [R5]
    clear_hit |=> dac_codes == {4{$past(clear_code)}})
    else $error("clear did not load the clear code");
  chk_clear_nop: assert property (@(posedge clk) disable iff (!reset_n) // [R6]
    (clr_fall && clear_code_select == QDU_CLR_NOP && !frame_done && !load_fall) |=> $stable(dac_codes))
    else $error("clear with nop select changed codes");
  chk_clear_abort: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
    (clr_fall && !link_s.sync_n) |=> (bitcnt == 6'h00 && !frame_done))
    else $error("frame survived a clear");
  chk_sync_discard: assert property (@(posedge clk) disable iff (!reset_n) // [R18]
    link_s.sync_n |=> (bitcnt == 6'h00 && !frame_done))
    else $error("partial frame kept after sync rise");
  chk_override_load: assert property (@(posedge clk) disable iff (!reset_n) // [R14]
    (frame_done && cf.cmd == QDU_CMD_OVERRIDE) |=> load_override_mask == $past(shreg[3:0]))
    else $error("override mask not loaded");
  chk_async_hold: assert property (@(posedge clk) disable iff (!reset_n) // [R12]
    (frame_done && cf.cmd == QDU_CMD_WRITE_IN && load_s && load_override_mask == 4'h0 && !clr_fall)
      |=> $stable(dac_codes))
    else $error("input write moved outputs with load high");
  chk_load_copy: assert property (@(posedge clk) disable iff (!reset_n) // [R12]
    (load_fall && !frame_done && !clr_fall) |=> dac_codes == $past(in_q))
    else $error("load edge did not copy inputs");
  chk_power_keep: assert property (@(posedge clk) disable iff (!reset_n) // [R19]
    (frame_done && cf.cmd == QDU_CMD_POWER && !clr_fall && !load_fall) |=> $stable(dac_codes))
    else $error("power mode frame changed codes");
  chk_power_sel: assert property (@(posedge clk) disable iff (!reset_n) // [R20]
    (frame_done && cf.cmd == QDU_CMD_POWER)
      |=> ((power_modes ^ $past(power_modes)) & ~$past(sel_pairs)) == 8'h00)
    else $error("unselected channel mode changed");
  chk_power_set: assert property (@(posedge clk) disable iff (!reset_n) // [R3]
    (frame_done && cf.cmd == QDU_CMD_POWER)
      |=> ((power_modes ^ {4{$past(cf.pmode)}}) & $past(sel_pairs)) == 8'h00)
    else $error("selected channel did not take the mode");
  chk_clear_exit: assert property (@(posedge clk) disable iff (!reset_n) // [R9]
    (frame_done && !clear_hit) |=> !clear_active)
    else $error("cleared state not left");
  chk_clear_flag: assert property (@(posedge clk) disable iff (!reset_n) // [R5]
    clear_hit |=> clear_active)
    else $error("clear did not enter cleared state");
  chk_clear_inputs: assert property (@(posedge clk) disable iff (!reset_n) // [R5]
    clear_hit |=> in_q == {4{$past(clear_code)}})
    else $error("clear did not load input registers");
  chk_clear_map: assert property (@(posedge clk) disable iff (!reset_n) // [R6]
    clear_hit |=> dac_codes[15:0] == (($past(clear_code_select) == QDU_CLR_MID) ? QDU_CODE_MID :
      ($past(clear_code_select) == QDU_CLR_FULL) ? QDU_CODE_FULL : QDU_CODE_ZERO))
    else $error("clear code mapping wrong");
  chk_clrsel_load: assert property (@(posedge clk) disable iff (!reset_n) // [R8]
    (frame_done && cf.cmd == QDU_CMD_CLRCODE) |=> clear_code_select == $past(cf.low4[1:0]))
    else $error("clear select not loaded");
  chk_frame_count: assert property (@(posedge clk) disable iff (!reset_n) // [R17]
    frame_done |-> $past(bitcnt) == 6'(QDU_FRAME_BITS - 1))
    else $error("frame executed before its last bit");
  // addr_dac is only meaningful for channel addresses 0..3
  chk_write_sync: assert property (@(posedge clk) disable iff (!reset_n) // [R11]
    (frame_done && cf.cmd == QDU_CMD_WRITE_IN && cf.addr < 4'h4 && !load_s && !clear_hit)
      |=> addr_dac == $past(cf.data))
    else $error("write with load low did not update");
  chk_override_upd: assert property (@(posedge clk) disable iff (!reset_n) // [R15]
    (frame_done && cf.cmd == QDU_CMD_WRITE_IN && cf.addr < 4'h4
      && load_override_mask[cf.addr[1:0]] && !clear_hit)
      |=> addr_dac == $past(cf.data))
    else $error("override channel did not update");
  chk_write_upd: assert property (@(posedge clk) disable iff (!reset_n) // [R17]
    (frame_done && cf.cmd == QDU_CMD_WRITE_UPD && cf.addr < 4'h4 && !clear_hit)
      |=> addr_dac == $past(cf.data))
    else $error("write and update did not land");
  chk_sw_load: assert property (@(posedge clk) disable iff (!reset_n) // [R13]
    (frame_done && cf.cmd == QDU_CMD_WRITE_ALL && !clear_hit) |=> dac_codes == in_q)
    else $error("software load did not copy inputs");
  chk_reset_cmd: assert property (@(posedge clk) disable iff (!reset_n) // [R7] [R16]
    (frame_done && cf.cmd == QDU_CMD_RESET && !clear_hit)
      |=> (dac_codes == {4{QDU_DAC_RESET}} && clear_code_select == QDU_CLRSEL_RESET
        && load_override_mask == QDU_OVERRIDE_RESET))
    else $error("reset command left state behind");
endmodule

// *** src/qdu_pkg.sv ***
/*
  Constants and carrier types for the quad DAC update control block.
  Assumes a 32-bit frame shifted MSB first on falling serial clock edges.
*/
package qdu_pkg;
  localparam int QDU_FRAME_BITS = 32;
  localparam int QDU_CMD_LSB = 24;
  localparam int QDU_ADDR_LSB = 20;
  localparam int QDU_DATA_LSB = 4;
  localparam int QDU_PMODE_LSB = 8;
  localparam int QDU_CLRSEL_LSB = 0;
  localparam int QDU_CHSEL_LSB = 0;
  localparam logic [3:0] QDU_CMD_WRITE_IN = 4'h0;
  localparam logic [3:0] QDU_CMD_UPDATE_N = 4'h1;
  localparam logic [3:0] QDU_CMD_WRITE_ALL = 4'h2;
  localparam logic [3:0] QDU_CMD_WRITE_UPD = 4'h3;
  localparam logic [3:0] QDU_CMD_POWER = 4'h4;
  localparam logic [3:0] QDU_CMD_CLRCODE = 4'h5;
  localparam logic [3:0] QDU_CMD_OVERRIDE = 4'h6;
  localparam logic [3:0] QDU_CMD_RESET = 4'h7;
  localparam logic [3:0] QDU_ADDR_ALL = 4'hF;
  localparam logic [1:0] QDU_PM_NORMAL = 2'h0;
  localparam logic [1:0] QDU_PM_1K = 2'h1;
  localparam logic [1:0] QDU_PM_100K = 2'h2;
  localparam logic [1:0] QDU_PM_TRISTATE = 2'h3;
  localparam logic [1:0] QDU_CLR_ZERO = 2'h0;
  localparam logic [1:0] QDU_CLR_MID = 2'h1;
  localparam logic [1:0] QDU_CLR_FULL = 2'h2;
  localparam logic [1:0] QDU_CLR_NOP = 2'h3;
  localparam logic [15:0] QDU_CODE_ZERO = 16'h0000;
  localparam logic [15:0] QDU_CODE_MID = 16'h8000;
  localparam logic [15:0] QDU_CODE_FULL = 16'hFFFF;
  localparam logic [1:0] QDU_CLRSEL_RESET = QDU_CLR_ZERO;
  localparam logic [3:0] QDU_OVERRIDE_RESET = 4'h0;
  localparam logic [15:0] QDU_DAC_RESET = QDU_CODE_ZERO;
  localparam logic [1:0] QDU_PMODE_RESET = QDU_PM_NORMAL;

  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [15:0] data;
    logic [1:0] pmode;
    logic [3:0] low4;
  } qdu_frame_t;

  typedef struct packed {
    logic sync_n;
    logic sclk;
    logic din;
  } qdu_link_t;
endpackage

// *** src/qdu_sync.sv ***
/*
  Two-flop synchroniser for a bundle of pin inputs.
  Assumes inputs are asynchronous to clk; output is the second stage only.
*/
`timescale 1ns/1ns
module qdu_sync
  import qdu_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk, // core clock
  input wire logic reset_n, // async reset, active low
  input wire logic [WIDTH-1:0] async_in, // raw pin levels
  output logic [WIDTH-1:0] sync_out // synchronised levels
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= INIT;
      sync_out <= INIT;
    end else begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// *** src/qdu_regmem.sv ***
/*
  Four-entry code memory used for input and DAC registers.
  Assumes one write port with per-entry enables; read data registered.
*/
`timescale 1ns/1ns
module qdu_regmem
  import qdu_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic reset_n, // async reset, active low
  input wire logic [3:0] wr_en, // per-channel write enable
  input wire logic [63:0] wr_data, // per-channel write codes
  output logic [63:0] rd_data // all entries, registered
);
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_ent
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          rd_data[i*16 +: 16] <= QDU_DAC_RESET;
        end else if (wr_en[i]) begin
          rd_data[i*16 +: 16] <= wr_data[i*16 +: 16];
        end
      end
    end
  endgenerate
endmodule

// *** test/qdu_host_model.sv ***
/*
  Host side of the three-wire link: shifts one frame MSB first.
  Assumes the caller runs send() from the bench's clk domain.
*/
`timescale 1ns/1ns
module qdu_host_model (
  input wire logic clk, // bench core clock
  output logic sync_n, // frame select, active low
  output logic sclk, // serial clock, parked high
  output logic din // serial data
);
  initial begin
    sync_n = 1'b1;
    sclk = 1'b1;
    din = 1'b0;
  end
  // nbits < 32 gives a cut-short frame; half sets the sclk half period in clk cycles
  task automatic send(input logic [31:0] word, input int nbits, input int half);
    int i;
    repeat (250) @(posedge clk); // frame gap above 1.9 us
    sync_n <= 1'b0;
    for (i = 0; i < nbits; i++) begin
      din <= word[31-i];
      repeat (half) @(posedge clk);
      sclk <= 1'b0;
      repeat (half) @(posedge clk);
      sclk <= 1'b1;
    end
    repeat (half) @(posedge clk);
    sync_n <= 1'b1;
    din <= ~din; // released line shows no stale bit
  endtask
endmodule

// *** test/quad_dac_update_control_test.sv ***
/*
  Self-checking bench for qdu_top: frames, load pin, override, power, clear.
  Assumes qdu_host_model drives the link; pins are driven here.
*/
`timescale 1ns/1ns
module quad_dac_update_control_test;
  import qdu_pkg::*;
  logic clk;
  logic reset_n = 1'b0;
  logic async_clear_n = 1'b1;
  logic load_outputs_n = 1'b1;
  logic sync_n, sclk, din, clear_active;
  logic [63:0] dac_codes;
  logic [63:0] e;
  logic [7:0] power_modes;
  logic [7:0] pm;
  logic [1:0] clear_code_select;
  logic [3:0] load_override_mask;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  qdu_top qdu_top_inst (.clk(clk), .reset_n(reset_n), .sync_n(sync_n), .sclk(sclk), .din(din),
    .async_clear_n(async_clear_n), .load_outputs_n(load_outputs_n), .dac_codes(dac_codes),
    .power_modes(power_modes), .clear_active(clear_active), .clear_code_select(clear_code_select),
    .load_override_mask(load_override_mask));
  qdu_host_model qdu_host_model_inst (.clk(clk), .sync_n(sync_n), .sclk(sclk), .din(din));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ---------------------------------------------
  // shared helpers
  // ---------------------------------------------
  function automatic logic [31:0] frm(logic [3:0] cmd, logic [3:0] addr, logic [15:0] code, logic [3:0] low);
    return {4'hA, cmd, addr, code, low};
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic send(input logic [31:0] w);
    qdu_host_model_inst.send(w, 32, 10);
    repeat (12) @(posedge clk);
  endtask
  task automatic results();
    if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      results();
    end
  end
  // ---------------------------------------------
  // scenarios
  // ---------------------------------------------
  task automatic t_reset();
    chk(dac_codes, 64'h0);
    chk({power_modes, clear_code_select, load_override_mask, clear_active}, 64'h0);
  endtask
  task automatic t_load_pin();
    load_outputs_n <= 1'b0;
    send(frm(QDU_CMD_WRITE_IN, 4'h0, 16'h1234, 4'h0));
    chk(dac_codes, 64'h1234);
    load_outputs_n <= 1'b1;
    send(frm(QDU_CMD_WRITE_IN, 4'h1, 16'hA5C3, 4'h0));
    chk(dac_codes, 64'h1234);
    @(posedge clk);
    load_outputs_n <= 1'b0;
    repeat (10) @(posedge clk);
    chk(dac_codes, 64'hA5C3_1234);
    load_outputs_n <= 1'b1;
  endtask
  task automatic t_override();
    send(frm(QDU_CMD_OVERRIDE, 4'h0, 16'hFFFF, 4'h4));
    chk(load_override_mask, 64'h4);
    send(frm(QDU_CMD_WRITE_IN, 4'h2, 16'h5A5A, 4'h0));
    chk(dac_codes, 64'h5A5A_A5C3_1234);
    send(frm(QDU_CMD_WRITE_IN, 4'h3, 16'h0F0F, 4'h0));
    chk(dac_codes, 64'h5A5A_A5C3_1234);
    send(frm(QDU_CMD_WRITE_ALL, 4'h0, 16'h7777, 4'h0));
    chk(dac_codes, 64'h0F0F_5A5A_A5C3_7777);
  endtask
  task automatic t_power();
    int k;
    pm = 8'hFF;
    send(frm(QDU_CMD_POWER, 4'h2, {10'h2AA, 2'h3, 4'h5}, 4'hF));
    chk(power_modes, pm);
    for (k = 0; k < 4; k++) begin
      pm[2*k+:2] = 2'(k);
      send(frm(QDU_CMD_POWER, 4'h9, {10'h155, 2'(k), 4'hA}, 4'(1 << k)));
      chk(power_modes, pm);
    end
    chk(dac_codes, 64'h0F0F_5A5A_A5C3_7777);
  endtask
  task automatic t_clear();
    int s;
    logic [15:0] c;
    for (s = 0; s < 4; s++) begin
      send(frm(QDU_CMD_CLRCODE, 4'h1, 16'hFFFC, {2'b10, 2'(s)}));
      chk(clear_code_select, 64'(s));
      send(frm(QDU_CMD_WRITE_UPD, QDU_ADDR_ALL, 16'h1357, 4'h0));
      c = (s == 0) ? 16'h0000 : (s == 1) ? 16'h8000 : (s == 2) ? 16'hFFFF : 16'h1357;
      @(posedge clk);
      async_clear_n <= 1'b0;
      repeat (8) @(posedge clk);
      chk(dac_codes, {4{c}});
      chk(clear_active, 64'(s != 3));
      send(frm(QDU_CMD_WRITE_UPD, 4'h0, 16'h2468, 4'h0));
      chk(dac_codes, {c, c, c, 16'h2468});
      chk(clear_active, 64'h0);
      async_clear_n <= 1'b1;
    end
  endtask
  task automatic t_cut_frames();
    e = 64'h1357_1357_1357_2468;
    qdu_host_model_inst.send(frm(QDU_CMD_WRITE_UPD, 4'h0, 16'hDEAD, 4'h0), 20, 10);
    repeat (12) @(posedge clk);
    chk(dac_codes, e);
    fork
      send(frm(QDU_CMD_WRITE_UPD, 4'h0, 16'hBEEF, 4'h0));
      begin
        repeat (300) @(posedge clk);
        async_clear_n <= 1'b0;
      end
    join
    chk(dac_codes, e);
    async_clear_n <= 1'b1;
  endtask
  task automatic t_update_reset();
    send(frm(QDU_CMD_WRITE_IN, 4'h3, 16'h4321, 4'h0));
    chk(dac_codes, 64'h1357_1357_1357_2468);
    send(frm(QDU_CMD_UPDATE_N, 4'h3, 16'h0000, 4'h0));
    chk(dac_codes, 64'h4321_1357_1357_2468);
    send(frm(QDU_CMD_RESET, 4'h0, 16'h0000, 4'h0));
    chk({power_modes, clear_code_select, load_override_mask, clear_active}, 64'h0);
    chk(dac_codes, 64'h0);
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset();
    t_load_pin();
    t_override();
    t_power();
    t_clear();
    t_cut_frames();
    t_update_reset();
    results();
  end
endmodule
